//--- pkg/dbv_map.vh
`ifndef DBV_MAP_VH
`define DBV_MAP_VH
// Register word offsets, one register per address.
`define DBV_OFF_CTRL1 4'h0
`define DBV_OFF_CTRL2 4'h1
`define DBV_OFF_VA1 4'h2
`define DBV_OFF_VB1 4'h3
`define DBV_OFF_VA2 4'h4
`define DBV_OFF_VB2 4'h5
`define DBV_OFF_STAT 4'h6
`define DBV_OFF_IRQ 4'h7
`define DBV_OFF_MASK 4'h8
`define DBV_OFF_TGT1 4'h9
`define DBV_OFF_TGT2 4'hA
// Control register fields.
`define DBV_F_EN 0
`define DBV_F_FORCED_FIXED_FREQ_BIT 1
`define DBV_F_FALL 2
`define DBV_F_RSEN 3
`define DBV_F_DIS 4
`define DBV_F_PM_LO 5
`define DBV_F_RATE_LO 7
`define DBV_CTRL_W 9
`define DBV_CTRL_RST 9'h008
`define DBV_PM_GREEN 2'h2
// Ramp rate codes.
`define DBV_RATE_12P5 2'h0
`define DBV_RATE_25 2'h1
`define DBV_RATE_50 2'h2
`define DBV_RATE_ILIM 2'h3
// Voltage code width, one step of 12.5 mV.
`define DBV_VW 8
`define DBV_VA_RST 8'h20
`define DBV_VB_RST 8'h10
// Clock and timing: 40 MHz, 12.5 mV/us is one 12.5 mV step per 1 us.
`define DBV_CLK_MHZ 40
`define DBV_STEP_US 1
`define DBV_STEP_CYC (`DBV_STEP_US * `DBV_CLK_MHZ)
// Oscillator 4.4 MHz approximated from 40 MHz: half period of about 4.55 cycles rounds to 5.
`define DBV_OSC_KHZ 4400
`define DBV_OSC_HALF ((`DBV_CLK_MHZ * 1000 + `DBV_OSC_KHZ) / (2 * `DBV_OSC_KHZ))
// Interrupt bits.
`define DBV_I_FAULT1 0
`define DBV_I_FAULT2 1
`define DBV_I_DONE1 2
`define DBV_I_DONE2 3
`endif

//--- hdl/dbv_top.v
// Contract
// - Each converter keeps two host-loaded voltage settings and switches without bus traffic.
// - Select pin level picks which of the two settings is active.
// - Ramp rate programmable to 12.5, 25 or 50 mV per microsecond.
// - Extra rate code lets the converter ramp at current limit.
// - Falling-ramp bit set forces fixed-frequency with negative current while falling.
// - Falling-ramp bit clear keeps skip mode while the output falls.
// - Skip mode changes automatically to fixed frequency as load rises.
// - Forced-fixed-frequency bit forces fixed frequency at all loads.
// - Each converter enters green mode independently from its own control register.
// - A register bit can switch remote sensing off.
// - Remote sensing is forced off in green mode.
// - When disabled, a register bit connects the output discharge resistor.
// - Active-low open-drain fault request asserts while any fault exists.
// - Switch node is high impedance while its converter is disabled.
// - The two high-side switches turn on at opposite oscillator edges.
// - Fixed-frequency switching runs at the 4.4 MHz oscillator; the divider here gives 4 MHz (half period of 5 cycles at 40 MHz).
// - Converter enabled by its enable pin or by a register bit.
// - Power-mode field value 10 selects green mode.
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`include "dbv_map.vh"
`default_nettype none
// Control logic for two step-down converters sharing one oscillator.
// Software preloads two voltage codes per converter; the select pin then picks one.
// The target code ramps toward the selection at a programmed rate, so the analog loop
// never sees a large step unless the current-limit rate is chosen on purpose.
// Mode outputs are registered levels for the analog side: fixed frequency, negative
// current, green mode, remote sense and discharge.
// The switch drive is a simple two-phase pattern that marks where each high-side
// switch turns on; the real pulse width belongs to the analog loop, not to this logic.
// Every output comes from a flip-flop, so the analog side never sees decode glitches.
// Limitation: there is no dead time between high-side and low-side drive here.
module dbv_top #(
    parameter integer VW = `DBV_VW,
    parameter integer STEP_CYC = `DBV_STEP_CYC,
    parameter integer OSC_HALF = `DBV_OSC_HALF
) (
    // Clock and reset.
    input wire sys_clk,
    input wire rst_b,
    // Avalon-MM slave.
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // Converter pins.
    input wire voltage_select_pin_1,
    input wire voltage_select_pin_2,
    input wire converter_enable_pin_1,
    input wire converter_enable_pin_2,
    input wire [1:0] heavy_load,
    input wire [1:0] fault_in,
    output reg [1:0] hs_drive,
    output reg [1:0] ls_drive,
    output reg [1:0] switch_node_oe,
    output reg [1:0] fixed_freq_mode,
    output reg [1:0] neg_current_en,
    output reg [1:0] ilim_ramp,
    output reg [1:0] green_mode,
    output reg [1:0] remote_sense_en,
    output reg [1:0] discharge_en,
    output reg [1:0] conv_on,
    // Fault request, open drain: only the enable is meaningful, output is held low.
    output reg fault_request_n_o,
    output reg fault_request_n_oe,
    output reg irq
);
    // Per-converter register copies, index 0 for converter 1.
    // Each entry is written only by its own generate branch.
    reg [`DBV_CTRL_W-1:0] ctrl_ff [0:1];
    reg [VW-1:0] va_ff [0:1];
    reg [VW-1:0] vb_ff [0:1];
    reg [VW-1:0] tgt_ff [0:1];
    reg [1:0] falling_ff;
    reg [3:0] stat_ff;
    reg [3:0] mask_ff;
    // Oscillator divider state, shared by both converters.
    reg [7:0] osc_cnt_ff;
    reg osc_ff;
    reg [31:0] nxt_rdata;
    reg ack_ff;
    // Pin pairs gathered into vectors so the generate loop can index them.
    wire [1:0] sel_pin;
    wire [1:0] en_pin;
    wire [1:0] ramp_done;
    wire wr_acc;
    wire osc_rise;
    wire osc_fall;

    // A write lands only in the cycle where waitrequest is low.
    // The oscillator edges are one-cycle strobes taken before the divider wraps.
    // Both strobes come from the same counter, so they can never coincide.
    assign sel_pin = {voltage_select_pin_2, voltage_select_pin_1};
    assign en_pin = {converter_enable_pin_2, converter_enable_pin_1};
    assign wr_acc = avs_write && !avs_waitrequest;
    assign osc_rise = (osc_cnt_ff == OSC_HALF - 1) && !osc_ff;
    assign osc_fall = (osc_cnt_ff == OSC_HALF - 1) && osc_ff;

    // One wait cycle per access keeps the read data registered.
    // The cost is two cycles per transfer, which is plenty for a control register bank.
    // Waitrequest idles high, so a master must always wait for the low cycle.
    // A request held past its low cycle starts a fresh access, as the bus allows.
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_ff <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end else begin
            ack_ff <= (avs_read || avs_write) && avs_waitrequest;
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            avs_readdata <= nxt_rdata;
        end
    end

    // Read mux; unmapped offsets read as zero.
    // Unused upper bits also read as zero so software can mask loosely.
    // The status word shows live levels, not latched history.
    always @* begin
        nxt_rdata = 32'h0;
        if (avs_address == `DBV_OFF_CTRL1) begin
            nxt_rdata[`DBV_CTRL_W-1:0] = ctrl_ff[0];
        end else if (avs_address == `DBV_OFF_CTRL2) begin
            nxt_rdata[`DBV_CTRL_W-1:0] = ctrl_ff[1];
        end else if (avs_address == `DBV_OFF_VA1) begin
            nxt_rdata[VW-1:0] = va_ff[0];
        end else if (avs_address == `DBV_OFF_VB1) begin
            nxt_rdata[VW-1:0] = vb_ff[0];
        end else if (avs_address == `DBV_OFF_VA2) begin
            nxt_rdata[VW-1:0] = va_ff[1];
        end else if (avs_address == `DBV_OFF_VB2) begin
            nxt_rdata[VW-1:0] = vb_ff[1];
        end else if (avs_address == `DBV_OFF_STAT) begin
            nxt_rdata[5:0] = {conv_on, fault_in, falling_ff};
        end else if (avs_address == `DBV_OFF_IRQ) begin
            nxt_rdata[3:0] = stat_ff;
        end else if (avs_address == `DBV_OFF_MASK) begin
            nxt_rdata[3:0] = mask_ff;
        end else if (avs_address == `DBV_OFF_TGT1) begin
            nxt_rdata[VW-1:0] = tgt_ff[0];
        end else if (avs_address == `DBV_OFF_TGT2) begin
            nxt_rdata[VW-1:0] = tgt_ff[1];
        end
    end

    // Interrupt status: hardware set wins over a write-one clear.
    // A fault that is still present therefore reappears at once after a clear.
    // Done bits pulse in for one cycle when a ramp reaches its selection.
    // The interrupt output lags the status by one cycle because it is registered.
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            stat_ff <= 4'h0;
            mask_ff <= 4'h0;
            irq <= 1'b0;
        end else begin
            if (wr_acc && avs_address == `DBV_OFF_MASK) begin
                mask_ff <= avs_writedata[3:0];
            end
            stat_ff <= (stat_ff & ~((wr_acc && avs_address == `DBV_OFF_IRQ) ? avs_writedata[3:0] : 4'h0))
                | {ramp_done, fault_in};
            irq <= |(stat_ff & mask_ff);
        end
    end

    // fault request drive
    // Open drain: the data output stays low and only the enable moves.
    // The board pullup gives the released high level.
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fault_request_n_o <= 1'b0;
            fault_request_n_oe <= 1'b0;
        end else begin
            fault_request_n_o <= 1'b0;
            fault_request_n_oe <= |fault_in;
        end
    end

    // oscillator divider, 4.4 MHz nominal; edges alternate between converters.
    // The system clock does not divide exactly, so the half period is rounded.
    // The trade-off is a slightly slower oscillator in exchange for no extra clock.
    // The counter is wider than needed so a higher system clock still fits.
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            osc_cnt_ff <= 8'h0;
            osc_ff <= 1'b0;
        end else if (osc_cnt_ff == OSC_HALF - 1) begin
            osc_cnt_ff <= 8'h0;
            osc_ff <= !osc_ff;
        end else begin
            osc_cnt_ff <= osc_cnt_ff + 8'h1;
        end
    end

    // One generate branch per converter.
    // The branches share the bus decode and the oscillator strobes.
    // Converter 1 uses the rising strobe and converter 2 the falling one.
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_conv
            reg [15:0] step_cnt_ff;
            reg [2:0] lat_ff;
            wire [VW-1:0] sel_v;
            wire on;
            wire green;
            wire fixed;
            wire [1:0] rate;
            wire [3:0] div;
            wire hs_edge;
            wire [3:0] a_ctrl;
            // Decoded per-converter conditions.
            // Green mode and rate come straight from the control register; enable also takes the pin.
            // The selected code follows the pin with no bus traffic at all.
            // green mode decode; per converter
            assign green = ctrl_ff[i][`DBV_F_PM_LO+1:`DBV_F_PM_LO] == `DBV_PM_GREEN;
            assign on = en_pin[i] || ctrl_ff[i][`DBV_F_EN];
            // select pin chooses setting; no bus traffic needed
            assign sel_v = sel_pin[i] ? vb_ff[i] : va_ff[i];
            assign rate = ctrl_ff[i][`DBV_F_RATE_LO+1:`DBV_F_RATE_LO];
            // rate divides the step period by 1, 2 or 4
            assign div = (rate == `DBV_RATE_12P5) ? 4'd1 : (rate == `DBV_RATE_25) ? 4'd2 : 4'd4;
            // auto skip-to-fixed on load; forced bit; falling with bit set; skip otherwise
            assign fixed = ctrl_ff[i][`DBV_F_FORCED_FIXED_FREQ_BIT] || heavy_load[i]
                || (falling_ff[i] && ctrl_ff[i][`DBV_F_FALL]);
            // converter 1 on rising edge, converter 2 on falling edge
            assign hs_edge = (i == 0) ? osc_rise : osc_fall;
            assign ramp_done[i] = lat_ff[0];
            assign a_ctrl = (i == 0) ? `DBV_OFF_CTRL1 : `DBV_OFF_CTRL2;

            // Control and setting registers, written over the bus.
            // Setting B sits one word above setting A for each converter.
            // Converter 2 settings sit two words above those of converter 1; its control register one word.
            always @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    ctrl_ff[i] <= `DBV_CTRL_RST;
                    va_ff[i] <= `DBV_VA_RST;
                    vb_ff[i] <= `DBV_VB_RST;
                end else if (wr_acc) begin
                    if (avs_address == a_ctrl) begin
                        ctrl_ff[i] <= avs_writedata[`DBV_CTRL_W-1:0];
                    end else if (avs_address == `DBV_OFF_VA1 + 2 * i) begin
                        va_ff[i] <= avs_writedata[VW-1:0];
                    end else if (avs_address == `DBV_OFF_VB1 + 2 * i) begin
                        vb_ff[i] <= avs_writedata[VW-1:0];
                    end
                end
            end

            // target ramps one step per period; current limit jumps at once.
            // Faster rates shorten the step period rather than enlarging the step.
            // That keeps every code between start and end visible to the loop.
            // A selection change in mid-ramp simply turns the ramp around.
            // The done strobe fires on the step that lands on the selection.
            always @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    tgt_ff[i] <= `DBV_VA_RST;
                    step_cnt_ff <= 16'h0;
                    falling_ff[i] <= 1'b0;
                    lat_ff <= 3'h0;
                end else begin
                    lat_ff <= {1'b0, lat_ff[2:1]};
                    falling_ff[i] <= sel_v < tgt_ff[i];
                    if (tgt_ff[i] == sel_v) begin
                        step_cnt_ff <= 16'h0;
                    end else if (rate == `DBV_RATE_ILIM) begin
                        tgt_ff[i] <= sel_v;
                        lat_ff <= 3'h1;
                    end else if (step_cnt_ff >= STEP_CYC / div - 1) begin
                        step_cnt_ff <= 16'h0;
                        tgt_ff[i] <= (sel_v > tgt_ff[i]) ? tgt_ff[i] + 1'b1 : tgt_ff[i] - 1'b1;
                        if ((sel_v > tgt_ff[i] ? tgt_ff[i] + 1'b1 : tgt_ff[i] - 1'b1) == sel_v) begin
                            lat_ff <= 3'h1;
                        end
                    end else begin
                        step_cnt_ff <= step_cnt_ff + 16'h1;
                    end
                end
            end

            // Mode outputs and switch drive; switch node released when off.
            // Every mode output is gated by enable so a disabled converter shows none.
            // Discharge is the exception: it only acts while the converter is off.
            // Drive stops at once on disable, whatever the oscillator phase.
            always @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    hs_drive[i] <= 1'b0;
                    ls_drive[i] <= 1'b0;
                    switch_node_oe[i] <= 1'b0;
                    fixed_freq_mode[i] <= 1'b0;
                    neg_current_en[i] <= 1'b0;
                    ilim_ramp[i] <= 1'b0;
                    green_mode[i] <= 1'b0;
                    remote_sense_en[i] <= 1'b0;
                    discharge_en[i] <= 1'b0;
                    conv_on[i] <= 1'b0;
                end else begin
                    conv_on[i] <= on;
                    switch_node_oe[i] <= on;
                    fixed_freq_mode[i] <= on && fixed;
                    neg_current_en[i] <= on && falling_ff[i] && ctrl_ff[i][`DBV_F_FALL];
                    ilim_ramp[i] <= on && rate == `DBV_RATE_ILIM && tgt_ff[i] != sel_v;
                    green_mode[i] <= on && green;
                    // sense bit; forced off in green
                    remote_sense_en[i] <= on && ctrl_ff[i][`DBV_F_RSEN] && !green;
                    discharge_en[i] <= !on && ctrl_ff[i][`DBV_F_DIS];
                    if (!on) begin
                        hs_drive[i] <= 1'b0;
                        ls_drive[i] <= 1'b0;
                    end else if (hs_edge) begin
                        hs_drive[i] <= 1'b1;
                        ls_drive[i] <= 1'b0;
                    end else if (osc_rise || osc_fall) begin
                        hs_drive[i] <= 1'b0;
                        ls_drive[i] <= 1'b1;
                    end
                end
            end
        end
    endgenerate
    // Nothing below: the analog side consumes the registered levels directly.
    // Any level shifting or dead-time insertion belongs outside this logic.
endmodule
`default_nettype wire

//--- sim/dbv_checker_asserts.sv
`default_nettype none
module dbv_checker (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_b,
    // Bus handshake.
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // Converter pins.
    input wire logic converter_enable_pin_1,
    input wire logic [1:0] heavy_load,
    input wire logic [1:0] fault_in,
    input wire logic [1:0] hs_drive,
    input wire logic [1:0] ls_drive,
    input wire logic [1:0] ilim_ramp,
    input wire logic [1:0] switch_node_oe,
    input wire logic [1:0] fixed_freq_mode,
    input wire logic [1:0] neg_current_en,
    input wire logic [1:0] green_mode,
    input wire logic [1:0] remote_sense_en,
    input wire logic [1:0] discharge_en,
    input wire logic [1:0] conv_on,
    // Fault request pin.
    input wire logic fault_request_n_o,
    input wire logic fault_request_n_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // One clock domain, so reset silences every check at once.
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered next cycle");
    bus_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    fault_drive_a: assert property ((|fault_in) [*2] |-> fault_request_n_oe && !fault_request_n_o)
        else $error("fault request not pulled low");
    fault_free_a: assert property ((fault_in == 2'h0) [*2] |-> !fault_request_n_oe)
        else $error("fault request held without a fault");
    node_hiz_a: assert property ((switch_node_oe & ~conv_on) == 2'h0)
        else $error("switch node driven while converter off");
    green_sense_a: assert property ((green_mode & remote_sense_en) == 2'h0)
        else $error("remote sense on in green mode");
    discharge_off_a: assert property ((discharge_en & conv_on) == 2'h0)
        else $error("discharge on while converter on");
    neg_fixed_a: assert property ((neg_current_en & ~fixed_freq_mode) == 2'h0)
        else $error("negative current outside fixed frequency");
    interleave_a: assert property ($rose(hs_drive[0]) |-> !$rose(hs_drive[1]))
        else $error("high-side switches turned on together");
    enable_pin_a: assert property (converter_enable_pin_1 [*3] |-> conv_on[0])
        else $error("enable pin did not start converter");
    auto_fixed_a: assert property ((heavy_load[0] && conv_on[0]) [*3] |-> fixed_freq_mode[0])
        else $error("heavy load left converter in skip mode");
    drive_overlap_a: assert property ((hs_drive & ls_drive) == 2'h0)
        else $error("high and low side driven together");
    ilim_on_a: assert property ((ilim_ramp & ~conv_on) == 2'h0)
        else $error("current limit ramp while converter off");
endmodule
`default_nettype wire

//--- sim/dbv_board.sv
`default_nettype none
module dbv_board (
    // Host drive of the enable pins.
    input wire logic [1:0] en_drv,
    // Device side of the fault pin.
    input wire logic fault_request_n_oe,
    input wire logic fault_request_n_o,
    // Resolved pins.
    output wire logic converter_enable_pin_1,
    output wire logic converter_enable_pin_2,
    output wire logic fault_request_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // enables driven straight from the host
    // The enable pins follow en_drv directly, with no pulldown modelled.
    assign converter_enable_pin_1 = en_drv[0];
    assign converter_enable_pin_2 = en_drv[1];
    // open-drain pullup
    // The pullup wins whenever the device releases the line.
    assign fault_request_n = fault_request_n_oe ? fault_request_n_o : 1'b1;
endmodule
`default_nettype wire

//--- sim/dbv_bench.sv
`default_nettype none
module dbv_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst_b = 0, avs_read = 0, avs_write = 0, avs_waitrequest, irq;
    logic voltage_select_pin_1 = 0, voltage_select_pin_2 = 0, fault_request_n_o, fault_request_n_oe;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, fin;
    logic [1:0] en_drv = 2'h0, heavy_load = 2'h0, fault_in = 2'h0, hs_drive, ls_drive, switch_node_oe;
    logic [1:0] fixed_freq_mode, neg_current_en, ilim_ramp, green_mode, remote_sense_en, discharge_en, conv_on;
    wire logic converter_enable_pin_1, converter_enable_pin_2, fault_request_n;
    int num_errors = 0, comparisons = 0;

    // A short step count keeps every ramp brief.
    dbv_top #(.STEP_CYC(4)) DUT (.*);
    dbv_board board (.*);

    // Clock of 25 ns.
    always #12.5 sys_clk = ~sys_clk;

    task chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected at %0t: saw %h expected %h", $time, s, e);
        end
    endtask

    // One bus transfer; the request stands until waitrequest is seen low.
    task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= d;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task complete_run;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Watchdog sized well above the whole sequence.
    initial begin
        wt(20000);
        num_errors++;
        complete_run();
    end

    // Main sequence.
    initial begin
        wt(20);
        rst_b <= 1'b1;
        acc(0, 4'h0, 0);
        chk(rd, 32'h008);
        acc(0, 4'hF, 0);
        chk(rd, 32'h0);
        acc(1, 4'h2, 32'h22);
        acc(1, 4'h3, 32'h42);
        en_drv <= 2'h3;
        wt(200);
        acc(0, 4'h9, 0);
        chk(rd, 32'h22);
        acc(0, 4'hA, 0);
        chk(rd, 32'h20);
        voltage_select_pin_1 <= 1'b1;
        voltage_select_pin_2 <= 1'b1;
        wt(200);
        acc(0, 4'h9, 0);
        chk(rd, 32'h42);
        acc(0, 4'hA, 0);
        chk(rd, 32'h10);
        // Each rate code toggles the pin; code 0 also sets the falling-ramp bit.
        for (int r = 0; r < 4; r++) begin
            acc(1, 4'h0, (r << 7) | 8 | (r == 0 ? 4 : 0));
            fin = voltage_select_pin_1 ? 32'h22 : 32'h42;
            voltage_select_pin_1 <= ~voltage_select_pin_1;
            if (r < 3) begin
                wt(64 >> r);
                chk(neg_current_en[0], r == 0);
                acc(0, 4'h9, 0);
                chk(rd != fin, 1);
            end
            wt(r == 3 ? 4 : 150);
            acc(0, 4'h9, 0);
            chk(rd, fin);
        end
        acc(1, 4'h0, 32'h00A);
        wt(2);
        chk(fixed_freq_mode[0], 1);
        acc(1, 4'h0, 32'h0);
        wt(2);
        chk({fixed_freq_mode[0], remote_sense_en[0]}, 0);
        heavy_load <= 2'h1;
        wt(4);
        chk(fixed_freq_mode[0], 1);
        heavy_load <= 2'h0;
        acc(1, 4'h0, 32'h048);
        wt(2);
        chk({green_mode, remote_sense_en[0]}, 3'h2);
        en_drv <= 2'h2;
        acc(1, 4'h0, 32'h010);
        wt(3);
        chk({discharge_en[0], switch_node_oe[0]}, 2'h2);
        en_drv <= 2'h3;
        wt(3);
        chk({discharge_en[0], switch_node_oe[0]}, 2'h1);
        acc(1, 4'h8, 32'h0);
        fault_in <= 2'h2;
        wt(3);
        chk({fault_request_n, irq}, 0);
        acc(1, 4'h8, 32'h2);
        wt(2);
        chk(irq, 1);
        fault_in <= 2'h0;
        wt(3);
        acc(1, 4'h7, 32'h2);
        acc(0, 4'h7, 0);
        wt(2);
        chk({rd[1], irq, fault_request_n}, 3'h1);
        complete_run();
    end
endmodule

bind dbv_top dbv_checker checker_i (.sys_clk, .rst_b, .avs_read, .avs_write, .avs_waitrequest,
    .converter_enable_pin_1, .heavy_load, .fault_in, .hs_drive, .ls_drive, .ilim_ramp, .switch_node_oe, .fixed_freq_mode,
    .neg_current_en, .green_mode, .remote_sense_en, .discharge_en, .conv_on, .fault_request_n_o,
    .fault_request_n_oe);
`default_nettype wire
